/* hdl/nmsm_pkg.sv */
// Package for the node mode state machine: modes, flag carrier, timing.
// Assumes a single 250 MHz clock domain for every user of these types.
package nmsm_pkg;
  // Clock period in picoseconds
  localparam int unsigned NMSM_CLK_PS = 4000;
  // Minimum Go-to-sleep hold time, in microseconds
  localparam int unsigned NMSM_GTS_HOLD_US = 20;
  // Hold time as clock cycles, rounded up, never below one
  localparam int unsigned NMSM_GTS_HOLD_CYC =
    ((NMSM_GTS_HOLD_US * 1000000 + NMSM_CLK_PS - 1) / NMSM_CLK_PS) < 1 ? 1 :
    ((NMSM_GTS_HOLD_US * 1000000 + NMSM_CLK_PS - 1) / NMSM_CLK_PS);
  // Host lead of mode_select_pin before low_power_select_n, microseconds
  localparam int unsigned NMSM_STBY_LEAD_US = 60;
  // Reset values of the flags
  localparam logic NMSM_WAKE_RST = 1'h0;
  localparam logic NMSM_UV_RST = 1'h0;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    NMSM_NORMAL = 5'h01,
    NMSM_RXONLY = 5'h02,
    NMSM_STANDBY = 5'h04,
    NMSM_GOTOSLEEP = 5'h08,
    NMSM_SLEEP = 5'h10
  } nmsm_mode_t;

  // Supply undervoltage flags
  typedef struct packed {
    logic io_supply_low_flag;
    logic battery_low_flag;
    logic core_supply_low_flag;
  } nmsm_uv_t;

  // Synchronised pin levels with their edges
  typedef struct packed {
    logic mode_lvl;
    logic mode_rise;
    logic mode_fall;
    logic lp_lvl;
    logic lp_rise;
    logic lp_fall;
  } nmsm_pins_t;
endpackage

/* hdl/nmsm_pin_sync.sv */
// Two-flop synchroniser plus edge detection for the two mode pins.
// Assumes asynchronous pins and the internal synchronous reset copy.
module nmsm_pin_sync
  import nmsm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire logic mode_select_pin_i,
  input wire logic low_power_select_n_i,
  // Conditioned result
  output nmsm_pins_t pins_o
);
  logic [1:0] meta_r; // First stage, read only by second stage
  logic [1:0] sync_r; // Second stage
  logic [1:0] prev_r; // Previous synced level, for edges

  // Synchroniser chain; pins reset low like the pull-downs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      prev_r <= 2'h0;
    end else begin
      meta_r <= {low_power_select_n_i, mode_select_pin_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges from synchronised values only
  always_comb begin
    pins_o.mode_lvl = sync_r[0];
    pins_o.mode_rise = sync_r[0] & ~prev_r[0];
    pins_o.mode_fall = ~sync_r[0] & prev_r[0];
    pins_o.lp_lvl = sync_r[1];
    pins_o.lp_rise = sync_r[1] & ~prev_r[1];
    pins_o.lp_fall = ~sync_r[1] & prev_r[1];
  end
endmodule

/* hdl/nmsm_top.sv */
// Node mode state machine: operating mode, wake flag, undervoltage flags.
// Assumes a host driving the two mode pins and a wake detector pulse on
// the same clock; undervoltage detection sits elsewhere and only sets.
//
// Contract
// - Normal exits by pin edges to three modes
// - Receive-only exits by pin levels and edges
// - Standby exits; wake follows the pin levels
// - Go-to-sleep exits; held pins lead Sleep
// - Early Go-to-sleep exits skip Sleep
// - Hold time expired without wake enters Sleep
// - Sleep exits by rising select, clearing flags
// - Rising low-power select sets wake flag
// - Ending in Normal clears wake flag
// - Setting wake clears all undervoltage flags
// - Standby wake-up: set wake, follow pins
// - Go-to-sleep wake-up: set wake, follow pins
// - Sleep wake-up: set wake, clear flags, follow
// - Sleep wake-up passes through Standby first
// - Pins rule unless undervoltage present
// - Standby with wake drives indications active
module nmsm_top
  import nmsm_pkg::*;
#(
  parameter int unsigned GTS_HOLD_CYC = NMSM_GTS_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Mode control pins from the host
  input wire logic mode_select_pin_i,
  input wire logic low_power_select_n_i,
  // Wake-up pulse from the wake detector, same clock
  input wire logic wake_event_i,
  // Undervoltage present and flag set pulses from the monitor
  input wire logic uv_present_i,
  input wire nmsm_uv_t uv_set_i,
  // Mode and flag status
  output nmsm_mode_t mode_o,
  output logic wake_flag_o,
  output nmsm_uv_t uv_flags_o,
  // Pin indications
  output logic inhibit_two_out_o,
  output logic inhibit_two_oe_n_o,
  output logic bus_activity_n_o,
  output logic receive_out_o
);
  // Counter width for the hold timer
  localparam int unsigned CW = $clog2(GTS_HOLD_CYC + 1) + 1;
  localparam logic [CW-1:0] HOLD_LIM = CW'(GTS_HOLD_CYC);

  logic [1:0] rst_sync_r; // Reset release chain
  logic rst_n; // Internal reset copy
  nmsm_pins_t pins; // Conditioned pins
  nmsm_mode_t mode_r; // Current mode
  nmsm_mode_t mode_nxt;
  logic wake_r; // Wake flag
  logic wake_nxt;
  nmsm_uv_t uv_r; // Undervoltage flags
  nmsm_uv_t uv_nxt;
  logic [CW-1:0] hold_r; // Cycles spent in Go-to-sleep
  logic hold_done; // Minimum hold time exceeded
  logic via_stby_r; // Sleep wake-up in transit via Standby
  logic via_stby_nxt;
  logic wake_set; // Wake flag sets this cycle
  logic uv_clr_all; // All three flags clear this cycle
  logic core_clr; // Core supply flag clears this cycle

  // Reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  // Every flop below resets from this copy, never from the raw pin
  assign rst_n = rst_sync_r[1];

  // Pin conditioning before any decision
  nmsm_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .mode_select_pin_i(mode_select_pin_i),
    .low_power_select_n_i(low_power_select_n_i),
    .pins_o(pins)
  );

  // Hold timer; saturates so a long stay cannot wrap back
  // Leaving Go-to-sleep restarts it, so every visit is timed afresh
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
    end else if (mode_r != NMSM_GOTOSLEEP) begin
      hold_r <= '0;
    end else if (hold_r <= HOLD_LIM) begin
      hold_r <= hold_r + CW'(1);
    end
  end
  // Exceeded, not merely reached: one cycle past the limit
  assign hold_done = hold_r > HOLD_LIM;

  // Mode selected by plain pin levels
  function automatic nmsm_mode_t pin_mode(input logic lp, input logic ms);
    nmsm_mode_t m;
    // Both pins low selects Standby, the default here
    m = NMSM_STANDBY;
    if (lp && ms) begin
      m = NMSM_NORMAL;
    end else if (lp) begin
      m = NMSM_RXONLY;
    end else if (ms) begin
      m = NMSM_GOTOSLEEP;
    end
    return m;
  endfunction

  // Next mode decision
  // Pin edges outrank wake-ups, and wake-ups outrank the Sleep timer
  always_comb begin
    mode_nxt = mode_r;
    via_stby_nxt = 1'h0;
    wake_set = 1'h0;
    uv_clr_all = 1'h0;
    core_clr = 1'h0;
    if (uv_present_i) begin
      // Undervoltage handling owns the mode; hold still
      // Limitation: a Sleep wake-up caught here stays in Standby
      mode_nxt = mode_r;
    end else if (via_stby_r) begin
      // Second step of a Sleep wake-up
      mode_nxt = pin_mode(pins.lp_lvl, pins.mode_lvl);
    end else begin
      case (mode_r)
        NMSM_NORMAL: begin
          // Edge driven exits
          if (pins.lp_fall && !pins.mode_lvl) begin
            mode_nxt = NMSM_STANDBY;
          end else if (pins.lp_fall && pins.mode_lvl) begin
            mode_nxt = NMSM_GOTOSLEEP;
          end else if (pins.mode_fall && pins.lp_lvl) begin
            mode_nxt = NMSM_RXONLY;
          end
        end
        NMSM_RXONLY: begin
          // Level and edge exits
          if (pins.mode_rise && pins.lp_lvl) begin
            mode_nxt = NMSM_NORMAL;
          end else if (!pins.lp_lvl && pins.mode_lvl) begin
            mode_nxt = NMSM_GOTOSLEEP;
          end else if (pins.lp_fall && !pins.mode_lvl) begin
            mode_nxt = NMSM_STANDBY;
          end
        end
        NMSM_STANDBY: begin
          if (pins.lp_rise) begin
            // Rising select picks Normal or Receive-only
            mode_nxt = pins.mode_lvl ? NMSM_NORMAL : NMSM_RXONLY;
          end else if (pins.mode_rise && !pins.lp_lvl) begin
            mode_nxt = NMSM_GOTOSLEEP;
          end else if (wake_event_i) begin
            // Wake-up follows the pins
            mode_nxt = pin_mode(pins.lp_lvl, pins.mode_lvl);
          end
          if (wake_event_i) begin
            wake_set = 1'h1;
            core_clr = 1'h1;
          end
        end
        NMSM_GOTOSLEEP: begin
          // Pin exits win at any time before Sleep
          if (pins.lp_rise) begin
            mode_nxt = pins.mode_lvl ? NMSM_NORMAL : NMSM_RXONLY;
          end else if (pins.mode_fall && !pins.lp_lvl) begin
            mode_nxt = NMSM_STANDBY;
          end else if (wake_event_i) begin
            mode_nxt = pin_mode(pins.lp_lvl, pins.mode_lvl);
          end else if (hold_done && !wake_r && !pins.lp_lvl && pins.mode_lvl) begin
            mode_nxt = NMSM_SLEEP;
          end
          if (wake_event_i) begin
            wake_set = 1'h1;
            core_clr = 1'h1;
          end
        end
        NMSM_SLEEP: begin
          if (pins.lp_rise) begin
            // Direct pin exit, flags clear
            mode_nxt = pins.mode_lvl ? NMSM_NORMAL : NMSM_RXONLY;
            uv_clr_all = 1'h1;
          end else if (wake_event_i) begin
            // Wake-up lands in Standby, then follows the pins
            mode_nxt = NMSM_STANDBY;
            via_stby_nxt = pin_mode(pins.lp_lvl, pins.mode_lvl) != NMSM_STANDBY;
            wake_set = 1'h1;
            uv_clr_all = 1'h1;
          end
        end
        default: begin
          mode_nxt = NMSM_STANDBY;
        end
      endcase
    end
    // Any rising select edge sets the wake flag
    if (pins.lp_rise) begin
      wake_set = 1'h1;
    end
    // Setting wake clears every undervoltage flag
    if (wake_set) begin
      uv_clr_all = 1'h1;
    end
  end

  // Mode and transit registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= NMSM_STANDBY;
      via_stby_r <= 1'h0;
    end else begin
      mode_r <= mode_nxt;
      via_stby_r <= via_stby_nxt;
    end
  end

  // Wake flag next value
  always_comb begin
    wake_nxt = wake_r;
    if (wake_set) begin
      wake_nxt = 1'h1;
    end
    // Sleep entry clears it; the entry test needs it clear anyway
    if (mode_r == NMSM_GOTOSLEEP && mode_nxt == NMSM_SLEEP) begin
      wake_nxt = 1'h0;
    end
    // Ending in Normal clears it, even if just set
    if (mode_nxt == NMSM_NORMAL) begin
      wake_nxt = 1'h0;
    end
  end

  // Wake flag register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= NMSM_WAKE_RST;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // Undervoltage flags: monitor set wins over a clear in the same cycle
  always_comb begin
    uv_nxt = uv_r;
    if (uv_clr_all) begin
      uv_nxt = '0;
    end else if (core_clr) begin
      uv_nxt.core_supply_low_flag = 1'h0;
    end
    // Monitor sets merge last, so they win over any clear
    uv_nxt = nmsm_uv_t'(uv_nxt | uv_set_i);
  end

  // Undervoltage flag register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      uv_r <= '{NMSM_UV_RST, NMSM_UV_RST, NMSM_UV_RST};
    end else begin
      uv_r <= uv_nxt;
    end
  end

  // Indication pins registered from the new state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      inhibit_two_out_o <= 1'h0;
      inhibit_two_oe_n_o <= 1'h1;
      bus_activity_n_o <= 1'h1;
      receive_out_o <= 1'h1;
    end else begin
      // Value fixed high; only the enable decides drive or float
      inhibit_two_out_o <= 1'h1;
      if (mode_nxt == NMSM_NORMAL || mode_nxt == NMSM_RXONLY) begin
        inhibit_two_oe_n_o <= 1'h0;
        bus_activity_n_o <= 1'h1;
        receive_out_o <= 1'h1;
      end else if (mode_nxt == NMSM_STANDBY && wake_nxt) begin
        inhibit_two_oe_n_o <= 1'h0;
        bus_activity_n_o <= 1'h0;
        receive_out_o <= 1'h0;
      end else begin
        inhibit_two_oe_n_o <= 1'h1;
        bus_activity_n_o <= 1'h1;
        receive_out_o <= 1'h1;
      end
    end
  end

  // Status outputs
  assign mode_o = mode_r;
  assign wake_flag_o = wake_r;
  assign uv_flags_o = uv_r;
endmodule

/* verif/nmsm_top_sva.sv */
// Checker for the node mode state machine, watching the top ports only.
// Assumes one clock and the asynchronous active-low reset input.
module nmsm_top_sva
  import nmsm_pkg::*;
#(
  parameter int unsigned GTS_HOLD_CYC = NMSM_GTS_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Host pins and monitor inputs
  input wire logic mode_select_pin_i,
  input wire logic low_power_select_n_i,
  input wire logic wake_event_i,
  input wire logic uv_present_i,
  input wire nmsm_uv_t uv_set_i,
  // Mode, flags and indications
  input wire nmsm_mode_t mode_o,
  input wire logic wake_flag_o,
  input wire nmsm_uv_t uv_flags_o,
  input wire logic inhibit_two_out_o,
  input wire logic inhibit_two_oe_n_o,
  input wire logic bus_activity_n_o,
  input wire logic receive_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Cycles spent in Go-to-sleep; wide enough for the full hold time
  logic [15:0] gts_cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) gts_cnt_r <= 16'h0000;
    else if (mode_o == NMSM_GOTOSLEEP) gts_cnt_r <= gts_cnt_r + 16'h0001;
    else gts_cnt_r <= 16'h0000;
  end
  norm_exit_a: assert property ($fell(mode_select_pin_i) && low_power_select_n_i
    && !uv_present_i && mode_o == NMSM_NORMAL |-> ##[1:8] mode_o == NMSM_RXONLY)
    else $error("Normal did not drop to Receive-only");
  stby_wake_a: assert property ($rose(low_power_select_n_i) && !mode_select_pin_i
    && !uv_present_i && mode_o == NMSM_STANDBY |-> ##[1:8] mode_o == NMSM_RXONLY && wake_flag_o)
    else $error("Standby select rise missed");
  norm_wake_a: assert property (mode_o == NMSM_NORMAL |-> !wake_flag_o)
    else $error("Wake flag set in Normal");
  uv_clear_a: assert property ($rose(wake_flag_o) && $past(uv_set_i) == 3'h0
    |-> uv_flags_o == 3'h0) else $error("Wake set left undervoltage flags");
  sby_ind_a: assert property (mode_o == NMSM_STANDBY && wake_flag_o |-> inhibit_two_out_o
    && !inhibit_two_oe_n_o && !bus_activity_n_o && !receive_out_o)
    else $error("Standby wake indications wrong");
  sleep_in_a: assert property ($changed(mode_o) && mode_o == NMSM_SLEEP
    |-> $past(mode_o) == NMSM_GOTOSLEEP && !wake_flag_o && gts_cnt_r >= GTS_HOLD_CYC)
    else $error("Sleep entered early or with wake");
  sleep_wake_a: assert property (mode_o == NMSM_SLEEP && wake_event_i && !uv_present_i
    && uv_set_i == 3'h0 |=> mode_o == NMSM_STANDBY && wake_flag_o && uv_flags_o == 3'h0)
    else $error("Sleep wake-up did not pass Standby");
  uv_hold_a: assert property ($past(uv_present_i) |-> $stable(mode_o))
    else $error("Mode moved under undervoltage");
endmodule

bind nmsm_top nmsm_top_sva #(.GTS_HOLD_CYC(GTS_HOLD_CYC)) u_nmsm_top_sva (.*);

/* verif/nmsm_host.sv */
// Host microcontroller model driving the two mode pins.
// Assumes the bench calls its tasks; pins move just after a rising edge.
module nmsm_host
  import nmsm_pkg::*;
#(
  // Mode pin lead over the select, in clock cycles
  parameter int unsigned LEAD_CYC = NMSM_STBY_LEAD_US * 1000000 / NMSM_CLK_PS
) (
  // Clock
  input wire logic clk_i,
  // Mode pins, always driven
  output logic mode_select_pin_o,
  output logic low_power_select_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both low so the device leaves reset quietly in Standby
  initial begin
    mode_select_pin_o = 1'b0;
    low_power_select_n_o = 1'b0;
  end
  // Set both pins together
  task automatic drive(input logic m, input logic l);
    @(posedge clk_i);
    mode_select_pin_o <= m;
    low_power_select_n_o <= l;
  endtask
  // Normal to Standby: mode pin leads the select by the fixed gap
  task automatic to_standby();
    drive(1'b0, 1'b1);
    repeat (LEAD_CYC) @(posedge clk_i);
    drive(1'b0, 1'b0);
  endtask
endmodule

/* verif/nmsm_top_tb.sv */
// Bench for the node mode state machine with a host pin model.
// Assumes a 250 MHz clock; hold time shortened so Sleep comes quickly.
module nmsm_top_tb
  import nmsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wake_event_i = 1'b0;
  logic uv_present_i = 1'b0;
  nmsm_uv_t uv_set_i = 3'h0;
  logic msel, lpsel, wake, inh, oe_n, bus_n, rx;
  nmsm_mode_t mode;
  nmsm_uv_t uv;
  int num_errors = 0;
  int tests_run = 0;
  // Clock, 4 ns period
  always #2 clk_i = ~clk_i;
  nmsm_host u_nmsm_host (.clk_i(clk_i), .mode_select_pin_o(msel), .low_power_select_n_o(lpsel));
  nmsm_top #(.GTS_HOLD_CYC(60)) u_nmsm_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .mode_select_pin_i(msel), .low_power_select_n_i(lpsel), .wake_event_i(wake_event_i),
    .uv_present_i(uv_present_i), .uv_set_i(uv_set_i), .mode_o(mode), .wake_flag_o(wake),
    .uv_flags_o(uv), .inhibit_two_out_o(inh), .inhibit_two_oe_n_o(oe_n),
    .bus_activity_n_o(bus_n), .receive_out_o(rx));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait for a mode, then compare
  task automatic wm(input nmsm_mode_t m);
    for (int i = 0; i < 200 && mode !== m; i++) @(negedge clk_i);
    chk(16'(mode), 16'(m));
  endtask
  // One-cycle pulses from the wake detector and the supply monitor
  task automatic pulse_wake();
    @(posedge clk_i);
    wake_event_i <= 1'b1;
    @(posedge clk_i);
    wake_event_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic set_uv();
    @(posedge clk_i);
    uv_set_i <= 3'h7;
    @(posedge clk_i);
    uv_set_i <= 3'h0;
    @(negedge clk_i);
    chk(16'(uv), 16'h0007);
  endtask
  task automatic t_standby_exit();
    chk(16'({mode, wake, oe_n, bus_n, rx}), 16'({NMSM_STANDBY, 4'h7}));
    set_uv();
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    chk(16'({wake, uv}), 16'h0008);
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    $display("standby exits done");
  endtask
  task automatic t_normal_gts();
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    u_nmsm_host.drive(1'b1, 1'b0);
    wm(NMSM_GOTOSLEEP);
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    u_nmsm_host.drive(1'b1, 1'b0);
    wm(NMSM_GOTOSLEEP);
    u_nmsm_host.drive(1'b0, 1'b0);
    wm(NMSM_STANDBY);
    u_nmsm_host.drive(1'b1, 1'b0);
    wm(NMSM_GOTOSLEEP);
    wm(NMSM_SLEEP);
    chk(16'({wake, oe_n}), 16'h0001);
    $display("normal and go-to-sleep done");
  endtask
  task automatic t_sleep_wake();
    set_uv();
    pulse_wake();
    chk(16'(mode), 16'(NMSM_STANDBY));
    @(negedge clk_i);
    chk(16'({mode, wake, uv}), 16'({NMSM_GOTOSLEEP, 4'h8}));
    // Wake set, so Sleep must be refused however long we wait
    repeat (80) @(negedge clk_i);
    chk(16'(mode), 16'(NMSM_GOTOSLEEP));
    set_uv();
    pulse_wake();
    chk(16'({mode, uv.core_supply_low_flag}), 16'({NMSM_GOTOSLEEP, 1'b0}));
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    $display("sleep wake-up done");
  endtask
  task automatic t_standby_ind();
    u_nmsm_host.to_standby();
    wm(NMSM_STANDBY);
    chk(16'({oe_n, bus_n, rx}), 16'h0007);
    set_uv();
    pulse_wake();
    chk(16'({mode, wake, uv}), 16'({NMSM_STANDBY, 4'h8}));
    chk(16'({inh, oe_n, bus_n, rx}), 16'h0008);
    $display("standby wake-up done");
  endtask
  task automatic t_sleep_lp();
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    chk(16'(wake), 16'h0001);
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    u_nmsm_host.drive(1'b1, 1'b0);
    wm(NMSM_SLEEP);
    set_uv();
    u_nmsm_host.drive(1'b0, 1'b0);
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    chk(16'({wake, uv}), 16'h0008);
    $display("sleep select exit done");
  endtask
  task automatic t_uv_hold();
    @(posedge clk_i);
    uv_present_i <= 1'b1;
    u_nmsm_host.drive(1'b1, 1'b1);
    repeat (20) @(negedge clk_i);
    chk(16'(mode), 16'(NMSM_RXONLY));
    u_nmsm_host.drive(1'b0, 1'b1);
    @(posedge clk_i);
    uv_present_i <= 1'b0;
    u_nmsm_host.drive(1'b1, 1'b1);
    wm(NMSM_NORMAL);
    $display("undervoltage hold done");
  endtask
  // Go-to-sleep left by select rise with mode pin falling, then Standby
  task automatic t_gts_rx();
    u_nmsm_host.drive(1'b1, 1'b0);
    wm(NMSM_GOTOSLEEP);
    u_nmsm_host.drive(1'b0, 1'b1);
    wm(NMSM_RXONLY);
    chk(16'(wake), 16'h0001);
    u_nmsm_host.drive(1'b0, 1'b0);
    wm(NMSM_STANDBY);
    chk(16'({wake, inh, oe_n, bus_n, rx}), 16'h0018);
    $display("go-to-sleep select exit done");
  endtask
  // Main sequence: reset, then the scenarios in order
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    t_standby_exit();
    t_normal_gts();
    t_sleep_wake();
    t_standby_ind();
    t_sleep_lp();
    t_uv_hold();
    t_gts_rx();
    complete_run();
  end
  // Watchdog: about two and a half times the expected run, the long lead gap dominating
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule
